// ### pkg/scss_pkg.sv
package scss_pkg;
   // clock_source_select encodings
   localparam logic [1:0] SEL_WAKEUP = 2'h0;
   localparam logic [1:0] SEL_LOOP = 2'h2;
   localparam logic [1:0] SEL_DIRECT = 2'h3;
   // oscillator_band_select encodings
   localparam logic [1:0] BAND_LOW = 2'h0;
   localparam logic [1:0] BAND_MID = 2'h1;
   localparam logic [1:0] BAND_HIGH = 2'h2;
   // field widths
   localparam int PRESCALE_W = 10;
   localparam int IN_DIV_W = 4;
   localparam int MUL_W = 6;
   localparam int OUT_DIV_W = 3;
   // register offsets
   localparam logic [3:0] ADDR_SYS_CFG = 4'h0;
   localparam logic [3:0] ADDR_LOOP_CFG = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   // reset values
   localparam logic [1:0] RST_SEL = 2'h0;
   localparam logic RST_BYPASS = 1'b1;
   localparam logic [9:0] RST_PRESCALE = 10'h000;
   localparam logic [3:0] RST_IN_DIV = 4'h0;
   localparam logic [5:0] RST_MUL = 6'h03;
   localparam logic [2:0] RST_OUT_DIV = 3'h1;
   localparam logic [1:0] RST_BAND = 2'h0;
   // gradual lock: one step of the loop divider per this many plus one reference ticks
   localparam logic [7:0] LOCK_STEP_CYC = 8'h10;
endpackage : scss_pkg

// ### rtl/scss_divider.sv
`timescale 1ns/1ps
// divides an enable train by (div_i+1); emits a level high for div_i/2+1 of each div_i+1 enables, and a pulse
module scss_divider
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic [10:0] div_i,
   output logic tick_o,
   output logic level_o
);
   typedef struct packed
   {
      logic [10:0] cnt;
      logic lvl;
      logic tick;
   } scss_div_st_t;
   scss_div_st_t st_r;
   scss_div_st_t st_nxt;
   logic [10:0] half;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      half = {1'b0, div_i[10:1]};
      if (en_i)
      begin
         if (st_r.cnt >= div_i)
         begin
            st_nxt.cnt = 11'h000;
            st_nxt.tick = 1'b1;
            st_nxt.lvl = 1'b1;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt + 11'h001;
            if (st_r.cnt >= half)
               st_nxt.lvl = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick_o = st_r.tick;
   assign level_o = (div_i == 11'h000) ? en_i : st_r.lvl;
endmodule : scss_divider

// ### rtl/scss_top.sv
`timescale 1ns/1ps
module scss_top
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic direct_clock_pin_i,
   input wire logic crystal_input_pin_i,
   input wire logic internal_clock_i,
   input wire logic wakeup_clock_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic sys_clk_o,
   output logic sys_tick_o,
   output logic loop_locked_o,
   output logic [1:0] active_source_o
);
   // all source and loop "clocks" are sampled levels in the mclk domain
   typedef struct packed
   {
      logic [1:0] sel;
      logic bypass;
      logic loop_in_internal;
      logic [9:0] prescale;
      logic [3:0] in_div;
      logic [5:0] mul;
      logic [2:0] out_div;
      logic [1:0] band;
      logic [1:0] act_src;
      logic act_bypass;
      logic switching;
      logic [10:0] cur_div;
      logic [7:0] step_cnt;
      logic [31:0] rdata;
      logic clk;
      logic tick;
      logic locked;
   } scss_st_t;

   scss_st_t st_r;
   scss_st_t st_nxt;

   // register hit for a strobe at a given offset
   function automatic logic hit(input logic strobe, input logic [3:0] addr,
                                input logic [3:0] offset);
      hit = strobe && (addr == offset);
   endfunction : hit

   // one gradual step of the loop divide toward its target
   function automatic logic [10:0] step_toward(input logic [10:0] cur,
                                               input logic [10:0] target);
      if (cur < target)
         step_toward = cur + 11'h001;
      else if (cur > target)
         step_toward = cur - 11'h001;
      else
         step_toward = cur;
   endfunction : step_toward

   function automatic logic [31:0] pack_sys(input scss_st_t s);
      pack_sys = {27'h0, s.loop_in_internal, 2'h0, s.sel};
   endfunction : pack_sys

   function automatic logic [31:0] pack_loop(input scss_st_t s);
      pack_loop = {2'h0, s.prescale, 2'h0, s.mul, s.in_div,
                   1'b0, s.out_div, 1'b0, s.band, s.bypass};
   endfunction : pack_loop

   function automatic logic [31:0] pack_status(input scss_st_t s);
      pack_status = {27'h0, s.switching, s.locked, s.act_bypass, s.act_src};
   endfunction : pack_status

   // sampled source selected by a given configuration
   function automatic logic src_level(input logic [1:0] sel, input logic byp,
                                      input logic pres_lvl, input logic loop_lvl);
      case (sel)
         scss_pkg::SEL_DIRECT: src_level = direct_clock_pin_i;
         scss_pkg::SEL_LOOP: src_level = byp ? pres_lvl : loop_lvl;
         scss_pkg::SEL_WAKEUP: src_level = wakeup_clock_i;
         default: src_level = wakeup_clock_i;
      endcase
   endfunction : src_level

   logic osc_lvl;
   logic osc_prev_r;
   logic osc_edge;
   logic pres_en;
   logic pres_lvl;
   logic ref_tick;
   logic vco_tick;
   logic [10:0] vco_div;
   logic loop_lvl;
   logic [10:0] target_div;
   logic [10:0] ref_div;
   logic [10:0] pres_div;
   logic cur_lvl;
   logic new_lvl;

   assign osc_lvl = st_r.loop_in_internal ? internal_clock_i : crystal_input_pin_i;
   assign osc_edge = osc_lvl & ~osc_prev_r;
   assign pres_div = {1'b0, st_r.prescale};
   assign ref_div = {7'h00, st_r.in_div};
   // oscillator period in ref cycles = P*K2/N, expressed as divide of ref edges
   assign target_div = 11'((({7'h00, st_r.in_div} + 11'h001) * ({8'h00, st_r.out_div} + 11'h001))
                            / ({5'h00, st_r.mul} + 11'h001));
   // divider takes factor minus one; a factor of zero rounds up to one
   assign vco_div = (st_r.cur_div == 11'h000) ? 11'h000 : st_r.cur_div - 11'h001;
   // factor one follows the source level, larger factors count its rising edges
   assign pres_en = (st_r.prescale == 10'h000) ? osc_lvl : osc_edge;

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         osc_prev_r <= 1'b0;
      else
         osc_prev_r <= osc_lvl;
   end

   // prescaler: factor prescale+1, factor one passes the source level
   scss_divider u_pres
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .en_i(pres_en),
      .div_i(pres_div),
      .tick_o(),
      .level_o(pres_lvl)
   );

   // loop: reference after input divider drives output stage through cur_div
   scss_divider u_ref
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .en_i(osc_edge),
      .div_i(ref_div),
      .tick_o(ref_tick),
      .level_o()
   );
   scss_divider u_vco
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .en_i(ref_tick),
      .div_i(vco_div),
      .tick_o(vco_tick),
      .level_o(loop_lvl)
   );

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h0000_0000;
      cur_lvl = 1'b0;
      new_lvl = 1'b0;
      // configuration writes; unmapped offsets are ignored
      if (hit(wr_i, addr_i, scss_pkg::ADDR_SYS_CFG))
      begin
         st_nxt.sel = wdata_i[1:0];
         st_nxt.loop_in_internal = wdata_i[4];
      end
      if (hit(wr_i, addr_i, scss_pkg::ADDR_LOOP_CFG))
      begin
         st_nxt.bypass = wdata_i[0];
         st_nxt.band = wdata_i[2:1];
         st_nxt.out_div = wdata_i[6:4];
         st_nxt.in_div = wdata_i[11:8];
         st_nxt.mul = wdata_i[17:12];
         st_nxt.prescale = wdata_i[29:20];
      end
      // read data stands only in the cycle after the strobe
      if (rd_i)
      begin
         case (addr_i)
            scss_pkg::ADDR_SYS_CFG:
               st_nxt.rdata = pack_sys(st_r);
            scss_pkg::ADDR_LOOP_CFG:
               st_nxt.rdata = pack_loop(st_r);
            scss_pkg::ADDR_STATUS:
               st_nxt.rdata = pack_status(st_r);
            default:
               st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // gradual lock: one divide step per interval of reference ticks,
      // so a rewritten loop factor other than in_div never makes the frequency jump
      st_nxt.locked = (st_r.cur_div == target_div);
      if (ref_tick && !st_nxt.locked)
      begin
         if (st_r.step_cnt >= scss_pkg::LOCK_STEP_CYC)
         begin
            st_nxt.step_cnt = 8'h00;
            st_nxt.cur_div = step_toward(st_r.cur_div, target_div);
         end
         else
         begin
            st_nxt.step_cnt = st_r.step_cnt + 8'h01;
         end
      end
      // glitch-free switch: wait for both old and new sources low
      cur_lvl = src_level(st_r.act_src, st_r.act_bypass, pres_lvl, loop_lvl);
      new_lvl = src_level(st_r.sel, st_r.bypass, pres_lvl, loop_lvl);
      st_nxt.switching = (st_r.sel != st_r.act_src) || (st_r.bypass != st_r.act_bypass);
      if (st_r.switching && !st_r.clk && !cur_lvl && !new_lvl)
      begin
         st_nxt.act_src = st_r.sel;
         st_nxt.act_bypass = st_r.bypass;
         st_nxt.clk = 1'b0;
      end
      else if (st_r.switching && !st_r.clk)
         st_nxt.clk = 1'b0;
      else
      begin
         st_nxt.clk = cur_lvl;
      end
      // tick marks each rising system clock edge
      st_nxt.tick = st_nxt.clk & ~st_r.clk;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         st_r <= '0;
         st_r.sel <= scss_pkg::RST_SEL;
         st_r.act_src <= scss_pkg::RST_SEL;
         st_r.bypass <= scss_pkg::RST_BYPASS;
         st_r.act_bypass <= scss_pkg::RST_BYPASS;
         st_r.prescale <= scss_pkg::RST_PRESCALE;
         st_r.in_div <= scss_pkg::RST_IN_DIV;
         st_r.mul <= scss_pkg::RST_MUL;
         st_r.out_div <= scss_pkg::RST_OUT_DIV;
         st_r.band <= scss_pkg::RST_BAND;
      end
      else
         st_r <= st_nxt;
   end

   assign rdata_o = st_r.rdata;
   assign sys_clk_o = st_r.clk;
   assign sys_tick_o = st_r.tick;
   assign loop_locked_o = st_r.locked;
   assign active_source_o = st_r.act_src;
endmodule : scss_top

// ### verification/scss_src_model.sv
`timescale 1ns/1ps
// free-running clock sources, one level each, stepped on mclk
module scss_src_model #(int DHI = 3, int DLO = 5, int XH = 2, int IH = 3, int WH = 10)
(
   input wire logic mclk_i,
   output logic direct_o,
   output logic xtal_o,
   output logic int_o,
   output logic wake_o
);
   int c = 0;
   initial {direct_o, xtal_o, int_o, wake_o} = 4'h0;
   // direct pin has an uneven duty so duty pass-through is visible
   always @(posedge mclk_i)
   begin
      c <= c + 1;
      direct_o <= (c % (DHI + DLO)) < DHI;
      xtal_o <= (c % (2 * XH)) < XH;
      int_o <= (c % (2 * IH)) < IH;
      wake_o <= (c % (2 * WH)) < WH;
   end
endmodule : scss_src_model

// ### verification/scss_top_sva.sv
`timescale 1ns/1ps
module scss_top_sva
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic sys_clk_o,
   input wire logic sys_tick_o,
   input wire logic loop_locked_o,
   input wire logic [1:0] active_source_o
);
   logic [31:0] wd_q;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge mclk_i)
      if (wr_i)
         wd_q <= wdata_i;
   sequence wr_rd_loop;
      wr_i && addr_i == scss_pkg::ADDR_LOOP_CFG ##1 rd_i && addr_i == scss_pkg::ADDR_LOOP_CFG;
   endsequence
   chk_sel_readback:
      assert property (wr_i && addr_i == scss_pkg::ADDR_SYS_CFG ##1 rd_i
         && addr_i == scss_pkg::ADDR_SYS_CFG |=> rdata_o[1:0] == wd_q[1:0])
      else $error("source select readback wrong");
   chk_prescale_rb:
      assert property (wr_rd_loop |=> rdata_o[29:20] == wd_q[29:20])
      else $error("prescale readback wrong");
   chk_band_rb:
      assert property (wr_rd_loop |=> rdata_o[2:1] == wd_q[2:1])
      else $error("band readback wrong");
   chk_status_src:
      assert property (rd_i && addr_i == scss_pkg::ADDR_STATUS |=>
         rdata_o[1:0] == $past(active_source_o) && rdata_o[3] == $past(loop_locked_o))
      else $error("status disagrees with outputs");
   chk_no_sel01:
      assert property (active_source_o != 2'h1)
      else $error("reserved source active");
   chk_tick_pulse:
      assert property (sys_tick_o |=> !sys_tick_o)
      else $error("tick longer than one cycle");
   chk_tick_on_rise:
      assert property ($rose(sys_clk_o) |-> ##[0:1] sys_tick_o)
      else $error("rising clock without tick");
   chk_switch_low:
      assert property ($changed(active_source_o) |-> !$past(sys_clk_o))
      else $error("source switched while clock high");
endmodule : scss_top_sva

// ### verification/scss_top_tb_top.sv
`timescale 1ns/1ps
module scss_top_tb_top;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic sys_clk_o, sys_tick_o, loop_locked_o, dp, xp, ip, wp;
   logic [1:0] active_source_o;
   int miscompares = 0;
   int num_checks = 0;
   always #4 mclk_i = ~mclk_i;
   scss_src_model i_scss_src_model (.mclk_i(mclk_i), .direct_o(dp), .xtal_o(xp), .int_o(ip),
      .wake_o(wp));
   scss_top i_scss_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .direct_clock_pin_i(dp),
      .crystal_input_pin_i(xp), .internal_clock_i(ip), .wakeup_clock_i(wp), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sys_clk_o(sys_clk_o),
      .sys_tick_o(sys_tick_o), .loop_locked_o(loop_locked_o), .active_source_o(active_source_o));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      cmp(rdata_o & m, e);
   endtask : rd
   // write then read back the same offset with no gap between strobes
   task automatic wrrd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      cmp(rdata_o & m, d & m);
   endtask : wrrd
   // cycles between two ticks and high cycles among them
   task automatic tick(output int n, output int h);
      n = 0;
      h = 0;
      do
      begin
         @(posedge mclk_i);
         n++;
         if (sys_clk_o === 1'b1)
            h++;
      end
      while (sys_tick_o !== 1'b1 && n < 9000);
   endtask : tick
   task automatic meas(input int per, input int hi);
      int n, h;
      repeat (3) tick(n, h);
      cmp(32'(n), 32'(per));
      cmp(32'(h), 32'(hi));
   endtask : meas
   function automatic logic [31:0] cfg(logic [9:0] p, logic [5:0] n, logic [2:0] k,
      logic [1:0] b, logic y);
      return {2'h0, p, 2'h0, n, scss_pkg::RST_IN_DIV, 1'b0, k, 1'b0, b, y};
   endfunction : cfg
   task automatic finish_test;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   initial
   begin
      #(8 * 60000);
      miscompares++;
      finish_test;
   end
   initial
   begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(scss_pkg::ADDR_SYS_CFG, 32'h0, 32'hffffffff);
      rd(scss_pkg::ADDR_LOOP_CFG, cfg(scss_pkg::RST_PRESCALE, scss_pkg::RST_MUL,
         scss_pkg::RST_OUT_DIV, scss_pkg::RST_BAND, scss_pkg::RST_BYPASS), 32'hffffffff);
      meas(20, 10);
      wr(4'hc, 32'hffffffff);
      rd(4'hc, 32'h0, 32'hffffffff);
      rd(scss_pkg::ADDR_SYS_CFG, 32'h0, 32'hffffffff);
      for (int b = 0; b < 3; b++)
      begin
         wrrd(scss_pkg::ADDR_LOOP_CFG, cfg(10'h0, scss_pkg::RST_MUL, 3'h1, 2'(b), 1'b1),
            32'h3ff3ff77);
      end
      wrrd(scss_pkg::ADDR_SYS_CFG, 32'h3, 32'h13);
      meas(8, 3);
      rd(scss_pkg::ADDR_STATUS, 32'h3, 32'h3);
      wr(scss_pkg::ADDR_SYS_CFG, 32'h2);
      meas(4, 2);
      rd(scss_pkg::ADDR_STATUS, 32'h6, 32'h7);
      wr(scss_pkg::ADDR_SYS_CFG, 32'h12);
      meas(6, 3);
      wr(scss_pkg::ADDR_SYS_CFG, 32'h2);
      wr(scss_pkg::ADDR_LOOP_CFG, cfg(10'h2, scss_pkg::RST_MUL, 3'h1, 2'h0, 1'b1));
      meas(12, 8);
      wr(scss_pkg::ADDR_LOOP_CFG, cfg(10'h3ff, scss_pkg::RST_MUL, 3'h1, 2'h0, 1'b1));
      meas(4096, 2048);
      wr(scss_pkg::ADDR_LOOP_CFG, cfg(10'h0, 6'h0, 3'h1, 2'h0, 1'b0));
      repeat (3) @(posedge mclk_i);
      cmp({31'h0, loop_locked_o}, 32'h0);
      for (int i = 0; i < 3000 && loop_locked_o !== 1'b1; i++)
         @(posedge mclk_i);
      cmp({31'h0, loop_locked_o}, 32'h1);
      meas(8, 4);
      wr(scss_pkg::ADDR_SYS_CFG, 32'h0);
      meas(20, 10);
      finish_test;
   end
endmodule : scss_top_tb_top
bind scss_top scss_top_sva i_scss_top_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sys_clk_o(sys_clk_o),
   .sys_tick_o(sys_tick_o), .loop_locked_o(loop_locked_o), .active_source_o(active_source_o));
